//--- verilog/asp_port.sv
// asynchronous serial port: double-buffered transmitter, receiver with
// ninth-bit detect, separate rx/tx request flip-flops and pin routing
// assumes rxd and all control inputs are synchronous to mclk
`timescale 1ns/1ps
module asp_port
    import asp_pkg::*;
#(
    parameter int DIV_W = 12,
    parameter bit HAS_ALT_D = 1'b1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [DIV_W-1:0] baud_div,
    input wire logic seven_bit,
    input wire asp_tx_wr_s tx_wr,
    input wire logic rx_rd,
    input wire logic rxd,
    input wire logic port_c_func_tx,
    input wire logic port_c_dout_tx,
    input wire logic port_d_alt_tx,
    input wire logic port_d_dout_tx,
    output logic [7:0] rx_data,
    output asp_status_s status,
    output logic rx_irq,
    output logic tx_irq,
    output logic irq,
    output logic tx_pin_c,
    output logic tx_pin_d
);

    typedef enum logic {TX_IDLE, TX_SHIFT} asp_tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_e;

    logic tick;

    asp_tick_div #(.DIV_W(DIV_W)) u_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .div(baud_div),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    asp_tx_state_e tx_st, next_tx_st;
    logic [10:0] tx_sh, next_tx_sh;
    logic [3:0] tx_left, next_tx_left;
    logic [3:0] tx_tick, next_tx_tick;
    logic buf_valid, next_buf_valid;
    logic [7:0] buf_data, next_buf_data;
    asp_tx_kind_e buf_kind, next_buf_kind;
    logic tx_req, next_tx_req;
    logic tx_done, tx_load, buf_take;
    asp_frame_s frame;

    // a write while the buffer is full is dropped; software waits for tx_irq
    always_comb begin
        next_tx_st = tx_st;
        next_tx_sh = tx_sh;
        next_tx_left = tx_left;
        next_tx_tick = tx_tick;
        next_buf_valid = buf_valid;
        next_buf_data = buf_data;
        next_buf_kind = buf_kind;
        frame = asp_frame(buf_data, buf_kind, seven_bit);
        buf_take = tx_wr.wr && !buf_valid;
        tx_done = (tx_st == TX_SHIFT) && tick && (tx_tick == TICK_LAST)
                && (tx_left == 4'h1);
        // reload straight from the buffer on the last tick: no idle gap
        tx_load = buf_valid && ((tx_st == TX_IDLE) || tx_done);
        if (tx_st == TX_SHIFT && tick) begin
            next_tx_tick = tx_tick + 4'h1;
            if (tx_tick == TICK_LAST) begin
                next_tx_sh = {1'b1, tx_sh[10:1]};
                next_tx_left = tx_left - 4'h1;
            end
        end
        if (tx_done) begin
            next_tx_st = TX_IDLE;
            next_tx_sh = LINE_IDLE;
        end
        if (tx_load) begin
            next_tx_st = TX_SHIFT;
            next_tx_sh = frame.bits;
            next_tx_left = frame.len;
            next_tx_tick = '0;
            next_buf_valid = 1'b0;
        end
        if (buf_take) begin
            next_buf_valid = 1'b1;
            next_buf_data = tx_wr.data;
            next_buf_kind = tx_wr.kind;
        end
        // buffer empties or the shifter drains: both raise the tx request
        next_tx_req = asp_flag(tx_req, tx_load || (tx_done && !buf_valid),
                tx_wr.wr);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_st <= TX_IDLE;
            tx_sh <= LINE_IDLE;
            tx_left <= '0;
            tx_tick <= '0;
            buf_valid <= 1'b0;
            buf_data <= '0;
            buf_kind <= TXK_NORMAL;
            tx_req <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tx_sh <= next_tx_sh;
            tx_left <= next_tx_left;
            tx_tick <= next_tx_tick;
            buf_valid <= next_buf_valid;
            buf_data <= next_buf_data;
            buf_kind <= next_buf_kind;
            tx_req <= next_tx_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    asp_rx_state_e rx_st, next_rx_st;
    logic [3:0] rx_tick, next_rx_tick;
    logic [3:0] rx_idx, next_rx_idx;
    logic [7:0] rx_sh, next_rx_sh;
    logic [7:0] next_rx_data;
    logic rx_full, next_rx_full;
    logic ninth_low, next_ninth_low;
    logic rx_deliver, rx_nl;

    // no address wake-up filter: every character is delivered
    always_comb begin
        next_rx_st = rx_st;
        next_rx_tick = rx_tick;
        next_rx_idx = rx_idx;
        next_rx_sh = rx_sh;
        next_rx_data = rx_data;
        next_ninth_low = ninth_low;
        rx_deliver = 1'b0;
        rx_nl = !seven_bit && !rxd;
        case (rx_st)
            RX_IDLE: begin
                if (tick && !rxd) begin
                    next_rx_st = RX_START;
                    next_rx_tick = '0;
                end
            end
            RX_START: begin
                if (tick) begin
                    next_rx_tick = rx_tick + 4'h1;
                    // glitch filter: start must still be low mid-bit
                    if (rx_tick == TICK_MID) begin
                        next_rx_st = rxd ? RX_IDLE : RX_BITS;
                        next_rx_tick = '0;
                        next_rx_idx = '0;
                        next_rx_sh = '0;
                    end
                end
            end
            RX_BITS: begin
                if (tick) begin
                    next_rx_tick = rx_tick + 4'h1;
                    if (rx_tick == TICK_LAST) begin
                        if (rx_idx < asp_data_bits(seven_bit)) begin
                            next_rx_sh[rx_idx[2:0]] = rxd;
                            next_rx_idx = rx_idx + 4'h1;
                        end else begin
                            // high ninth bit is just a stop bit; low is
                            // flagged and the next start is hunted at once
                            rx_deliver = 1'b1;
                            next_rx_data = rx_sh;
                            next_ninth_low = rx_nl;
                            next_rx_st = RX_IDLE;
                        end
                    end
                end
            end
            default: next_rx_st = RX_IDLE;
        endcase
        // a new character overwrites an unread one
        next_rx_full = asp_flag(rx_full, rx_deliver, rx_rd);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_st <= RX_IDLE;
            rx_tick <= '0;
            rx_idx <= '0;
            rx_sh <= '0;
            rx_data <= '0;
            rx_full <= 1'b0;
            ninth_low <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            rx_tick <= next_rx_tick;
            rx_idx <= next_rx_idx;
            rx_sh <= next_rx_sh;
            rx_data <= next_rx_data;
            rx_full <= next_rx_full;
            ninth_low <= next_ninth_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status, requests and pin routing
    logic next_pin_c, next_pin_d;

    always_comb begin
        status = '0;
        status.rx_full = rx_full;
        status.ninth_low = ninth_low;
        status.tx_buf_full = buf_valid;
        status.tx_busy = (tx_st == TX_SHIFT);
        rx_irq = rx_full;
        tx_irq = tx_req;
        irq = rx_full | tx_req;
    end

    // dummy characters stay off pin C once its function bit drops; pin D still carries them while port_d_alt_tx is set
    always_comb begin
        next_pin_c = port_c_func_tx ? tx_sh[0] : port_c_dout_tx;
        next_pin_d = (HAS_ALT_D && port_d_alt_tx) ? tx_sh[0] : port_d_dout_tx;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_pin_c <= 1'b1;
            tx_pin_d <= 1'b1;
        end else begin
            tx_pin_c <= next_pin_c;
            tx_pin_d <= next_pin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [3:0] chk_len;
    always_ff @(posedge mclk) begin
        if (sys_rst) chk_len <= '0;
        else if (tx_load) chk_len <= frame.len;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    rx_full_set_a: assert property (rx_deliver |=> rx_full && rx_irq)
        else $error("rx full not set after character");
    rx_rd_clear_a: assert property (rx_rd && !rx_deliver |=> !rx_full)
        else $error("rx read did not clear request");
    ninth_flag_a: assert property (rx_deliver |=> ninth_low == $past(rx_nl))
        else $error("ninth low flag wrong");
    gapless_load_a: assert property (tx_done && buf_valid |=> tx_st == TX_SHIFT
            && tx_sh[0] == 1'b0)
        else $error("gap between buffered characters");
    frame_len_a: assert property (tx_load |=> chk_len == asp_data_bits($past(seven_bit))
            + FRAME_OVERHEAD + 4'(($past(buf_kind) != TXK_NORMAL)))
        else $error("frame length wrong");
    tx_empty_req_a: assert property (tx_load && !tx_wr.wr |=> tx_req)
        else $error("tx empty did not request");
    tx_idle_req_a: assert property (tx_done && !buf_valid && !tx_wr.wr
            |=> tx_req && tx_st == TX_IDLE && tx_sh[0])
        else $error("tx idle did not request");
    both_req_a: assert property (rx_deliver && tx_load && !rx_rd && !tx_wr.wr
            |=> rx_irq && tx_irq)
        else $error("request lost when both fire");
    pin_route_a: assert property (1'b1 |=> tx_pin_c == ($past(port_c_func_tx)
            ? $past(tx_sh[0]) : $past(port_c_dout_tx)))
        else $error("port c routing wrong");
    ninth_low_tx_a: assert property (tx_load && buf_kind == TXK_NINTH_LOW && !seven_bit
            |=> tx_sh[9] == 1'b0 && tx_sh[10])
        else $error("ninth low bit not framed");

    cov_back_to_back_c: cover property (tx_done ##1 tx_st == TX_SHIFT);
    cov_ninth_low_c: cover property (rx_deliver && rx_nl);
    cov_long_stop_c: cover property (tx_load && buf_kind == TXK_LONG_STOP);
    cov_both_c: cover property (rx_deliver && tx_load);

endmodule : asp_port

//--- verilog/asp_pkg.sv
// constants, types and frame helpers for the asynchronous serial port
// assumes one clock and a synchronous active-high reset around it
// Behaviour
// - tx buffer refills shifter with no gap
// - tx request period is 9, 10 or 11 bits
// - held-low line gives zero characters, ninth low
// - ninth bit zero sets status bit 6
// - high ninth bit is extra stop, no error
// - ninth-low write sends ninth bit low
// - long-stop write sends ninth bit high
// - ninth-bit character takes 11, normal 10 (10 and 9 in seven-bit mode)
// - no wake-up filter, every character interrupts
// - interrupt on rx full and tx empty
// - interrupt when last stop bit leaves
// - port C function bit routes tx to pin
// - only ports A and B have port D output
// - shared vector, separate request flip-flops
// - reading rx data clears rx request
package asp_pkg;

    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] DATA_BITS8 = 4'h8;
    localparam logic [3:0] DATA_BITS7 = 4'h7;
    localparam logic [3:0] FRAME_OVERHEAD = 4'h2;
    localparam logic [10:0] LINE_IDLE = 11'h7ff;

    // which of the three send registers was written
    typedef enum logic [1:0] {
        TXK_NORMAL,
        TXK_NINTH_LOW,
        TXK_LONG_STOP
    } asp_tx_kind_e;

    typedef struct packed {
        logic wr;
        asp_tx_kind_e kind;
        logic [7:0] data;
    } asp_tx_wr_s;

    // serial_status_register layout, bit 7 down to bit 0
    typedef struct packed {
        logic rx_full;
        logic ninth_low;
        logic [1:0] rsv_hi;
        logic tx_buf_full;
        logic tx_busy;
        logic [1:0] rsv_lo;
    } asp_status_s;

    typedef struct packed {
        logic [10:0] bits;
        logic [3:0] len;
    } asp_frame_s;

    function automatic logic [3:0] asp_data_bits(input logic seven);
        asp_data_bits = seven ? DATA_BITS7 : DATA_BITS8;
    endfunction : asp_data_bits

    // lsb-first frame: start, data, optional ninth, stop
    function automatic asp_frame_s asp_frame(input logic [7:0] data,
            input asp_tx_kind_e kind, input logic seven);
        asp_frame_s f;
        logic [3:0] n;
        f.bits = LINE_IDLE;
        n = asp_data_bits(seven);
        f.bits[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n)) f.bits[i + 1] = data[i];
        end
        f.len = n + FRAME_OVERHEAD;
        if (kind != TXK_NORMAL) begin
            f.bits[n + 4'h1] = (kind == TXK_LONG_STOP);
            f.len = f.len + 4'h1;
        end
        asp_frame = f;
    endfunction : asp_frame

    // hardware set wins over a clear in the same cycle
    function automatic logic asp_flag(input logic q, input logic set, input logic clr);
        asp_flag = set | (q & ~clr);
    endfunction : asp_flag

endpackage : asp_pkg

//--- verilog/asp_tick_div.sv
// oversampling tick divider for the serial port
// assumes the divisor is held steady while a character is on the line
`timescale 1ns/1ps
module asp_tick_div
    import asp_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic next_tick;

    generate
        if (DIV_W < 1) begin : g_bad
            $error("asp_tick_div needs DIV_W of at least one");
        end
    endgenerate

    // one pulse every div+1 cycles, so div of zero gives a tick each cycle
    always_comb begin
        next_tick = (cnt == '0);
        next_cnt = next_tick ? div : cnt - 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule : asp_tick_div

//--- sim/asp_remote.sv
// remote serial station: sends frames on rxd and decodes frames on txl
// assumes BIT mclk cycles per bit and frame_len bits per frame seen
`timescale 1ns/1ps
module asp_remote #(
    parameter int BIT = 16
) (
    input wire logic mclk,
    input wire logic txl,
    input wire logic [3:0] frame_len,
    output logic rxd
);
    logic [10:0] cap = 11'h7ff;
    logic [10:0] capf;
    int ncap = 0;

    initial rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // one frame out, lsb first, line left idle high after it
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge mclk);
        end
        @(posedge mclk);
        rxd <= 1'b1;
    endtask : send

    // break: line low for a long time, then back to idle
    task automatic hold_low(input int cycles);
        @(posedge mclk);
        rxd <= 1'b0;
        repeat (cycles) @(posedge mclk);
        rxd <= 1'b1;
    endtask : hold_low

    ////////////////////////////////////////////////////////////////////
    // mid-bit sampling, so a one-cycle longer first bit still reads right
    initial forever begin
        @(posedge mclk);
        if (txl === 1'b0) begin
            capf = 11'h7ff;
            for (int i = 0; i < int'(frame_len); i++) begin
                repeat ((i == 0) ? BIT / 2 : BIT) @(posedge mclk);
                capf[i] = txl;
            end
            cap = capf;
            ncap++;
        end
    end
endmodule : asp_remote

//--- sim/testbench.sv
// self-checking bench for the serial port with a remote station model
// assumes baud_div 0, so one bit is 16 mclk cycles
`timescale 1ns/1ps
module testbench
    import asp_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic seven_bit = 1'b0;
    logic rx_rd = 1'b0;
    logic pc_f = 1'b1;
    logic pc_d = 1'b1;
    logic pd_a = 1'b0;
    logic pd_d = 1'b1;
    asp_tx_wr_s tx_wr = '0;
    logic [7:0] rx_data;
    asp_status_s status;
    logic rx_irq, tx_irq, irq, tx_pin_c, tx_pin_d, rxd;
    logic [3:0] flen = 4'ha;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int lows_c = 0;
    int lows_d = 0;

    always #2 mclk = ~mclk;

    // cycle count and low-time count on both pins
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tx_pin_c === 1'b0) lows_c <= lows_c + 1;
        if (tx_pin_d === 1'b0) lows_d <= lows_d + 1;
    end

    asp_port #(.DIV_W(12), .HAS_ALT_D(1'b1)) asp_port_inst (
        .mclk(mclk), .sys_rst(sys_rst), .baud_div(12'h000),
        .seven_bit(seven_bit), .tx_wr(tx_wr), .rx_rd(rx_rd), .rxd(rxd),
        .port_c_func_tx(pc_f), .port_c_dout_tx(pc_d),
        .port_d_alt_tx(pd_a), .port_d_dout_tx(pd_d), .rx_data(rx_data),
        .status(status), .rx_irq(rx_irq), .tx_irq(tx_irq), .irq(irq),
        .tx_pin_c(tx_pin_c), .tx_pin_d(tx_pin_d)
    );
    asp_remote #(.BIT(16)) asp_remote_inst (
        .mclk(mclk), .txl(tx_pin_c), .frame_len(flen), .rxd(rxd)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    function automatic logic done(input int w);
        case (w)
            0: done = (tx_irq === 1'b1);
            1: done = (status.rx_full === 1'b1);
            default: done = (status.tx_busy === 1'b0) && (status.tx_buf_full === 1'b0);
        endcase
    endfunction : done

    // bounded wait; a hang ends the run with a failure
    task automatic wait_for(input int w);
        for (int i = 0; i < 4000; i++) begin
            @(posedge mclk);
            #1;
            if (done(w)) return;
        end
        num_errors++;
        $display("CHECK FAILED at %0t: wait %h timed out", $time, w);
        summarize();
    endtask : wait_for

    task automatic wr(input asp_tx_kind_e k, input logic [7:0] d);
        @(posedge mclk);
        tx_wr <= '{wr: 1'b1, kind: k, data: d};
        @(posedge mclk);
        tx_wr.wr <= 1'b0;
    endtask : wr

    task automatic pulse_rd;
        @(posedge mclk);
        rx_rd <= 1'b1;
        @(posedge mclk);
        rx_rd <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : pulse_rd

    // expected line bits; ninth below zero means no ninth bit
    function automatic logic [10:0] frame(input logic [7:0] d, input int nb, input int ninth);
        logic [10:0] f;
        f = 11'h7ff;
        f[0] = 1'b0;
        for (int i = 0; i < nb; i++) f[i + 1] = d[i];
        if (ninth >= 0) f[nb + 1] = ninth[0];
        return f;
    endfunction : frame

    ////////////////////////////////////////////////////////////////////
    // three back-to-back characters: period, gap-free, idle request, framing
    task automatic tx_run(input asp_tx_kind_e k, input logic s);
        int nb, nn, t1, base;
        nb = s ? 7 : 8;
        nn = (k == TXK_NORMAL) ? -1 : int'(k == TXK_LONG_STOP);
        @(posedge mclk);
        seven_bit <= s;
        flen <= 4'(nb + 2 + int'(k != TXK_NORMAL));
        base = asp_remote_inst.ncap;
        wr(k, 8'h5a);
        wait_for(0);
        wr(k, 8'h96);
        wait_for(0);
        t1 = cyc;
        wr(k, 8'hc3);
        wait_for(0);
        check(16'(cyc - t1), 16'(flen) * 16'h10);
        wait_for(2);
        check(16'(tx_irq), 16'h1);
        repeat (16) @(posedge mclk);
        check(16'(asp_remote_inst.ncap - base), 16'h3);
        check(16'(asp_remote_inst.cap), 16'(frame(8'hc3, nb, nn)));
    endtask : tx_run

    // one received character while the tx idle request is pending
    task automatic rx_one(input logic [10:0] f, input int n, input logic [7:0] d, input logic nl);
        asp_remote_inst.send(f, n);
        wait_for(1);
        check(16'(rx_data), 16'(d));
        check(16'(status.ninth_low), 16'(nl));
        check(16'({tx_irq, rx_irq, irq}), 16'h7);
        pulse_rd();
        check(16'({tx_irq, status.rx_full, irq}), 16'h5);
    endtask : rx_one

    ////////////////////////////////////////////////////////////////////
    initial begin
        int base, lc, ld;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        check(16'({status, tx_irq, rx_irq, irq, tx_pin_c, tx_pin_d}), 16'h0003);
        tx_run(TXK_NORMAL, 1'b0);
        tx_run(TXK_NINTH_LOW, 1'b0);
        tx_run(TXK_LONG_STOP, 1'b0);
        tx_run(TXK_NORMAL, 1'b1);
        @(posedge mclk);
        seven_bit <= 1'b0;
        rx_one(frame(8'ha5, 8, -1), 10, 8'ha5, 1'b0);
        rx_one(frame(8'h3c, 8, 0), 11, 8'h3c, 1'b1);
        rx_one(frame(8'hc3, 8, 1), 11, 8'hc3, 1'b0);
        // break: zero characters with ninth low, one after another
        fork
            asp_remote_inst.hold_low(320);
            repeat (2) begin
                wait_for(1);
                check(16'({rx_data, status.ninth_low}), 16'h0001);
                pulse_rd();
            end
        join
        repeat (200) @(posedge mclk);
        #1;
        if (status.rx_full === 1'b1) pulse_rd();
        // dummy character: unrouted from port C, routed to port D
        @(posedge mclk);
        pc_f <= 1'b0;
        pd_a <= 1'b1;
        base = asp_remote_inst.ncap;
        lc = lows_c;
        ld = lows_d;
        wr(TXK_NORMAL, 8'h00);
        wait_for(0);
        wait_for(2);
        check(16'(lows_c - lc), 16'h0);
        check(16'(asp_remote_inst.ncap - base), 16'h0);
        check(16'(lows_d - ld >= 144), 16'h1);
        // route back only once idle, then the data bit drives the pin
        @(posedge mclk);
        pc_f <= 1'b1;
        @(posedge mclk);
        pc_f <= 1'b0;
        pc_d <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check(16'(tx_pin_c), 16'h0);
        summarize();
    end
endmodule : testbench
